// ### adc_output_port.sv
`timescale 1ns/1ps
`default_nettype none
module adc_output_port
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic                      sleep_request_pin,
  input  wire logic [15:0]               analog_level,
  input  wire adc_port_pkg::ref_levels_t refs,
  output logic [7:0]                     data_word_q
);
  import adc_port_pkg::*;

  // ----------------------------------------------------------------
  // Sampling on the falling edge
  // ----------------------------------------------------------------
  logic              run;
  logic [WORD_W-1:0] quant_code;
  logic [WORD_W-1:0] hold_q;
  logic [WORD_W-1:0] stage1_q;
  logic [WORD_W-1:0] stage2_q;

  assign run = clk_en && !sleep_request_pin;

  level_quantizer u_quant
  (
    .level (analog_level),
    .refs  (refs),
    .code  (quant_code)
  );

  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      hold_q <= RESET_CODE;
    else if (run)
      hold_q <= quant_code;
  end

  // ----------------------------------------------------------------
  // Rising-edge pipeline to the output word
  // ----------------------------------------------------------------
  pipe_stage #(.W(WORD_W)) u_stage1
  (
    .clk (clk),
    .rst (rst),
    .adv (run),
    .d   (hold_q),
    .q   (stage1_q)
  );

  pipe_stage #(.W(WORD_W)) u_stage2
  (
    .clk (clk),
    .rst (rst),
    .adv (run),
    .d   (stage1_q),
    .q   (stage2_q)
  );

  pipe_stage #(.W(WORD_W)) u_stage_out
  (
    .clk (clk),
    .rst (rst),
    .adv (run),
    .d   (stage2_q),
    .q   (data_word_q)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fall_capture: assert property (
    @(negedge clk) disable iff (rst)
    run |=> hold_q == $past(quant_code))
    else $error("hold register missed the falling-edge sample");

  a_pipe_latency: assert property (
    @(posedge clk) disable iff (rst)
    run ##1 run ##1 run |=> data_word_q == $past(hold_q, 3))
    else $error("output word does not follow the sample by 2.5 cycles");

  a_range_code: assert property (
    @(posedge clk) disable iff (rst)
    analog_level == refs.reference_bottom_level |-> quant_code == CODE_ZERO)
    else $error("bottom level does not give code zero");

  a_below_floor: assert property (
    @(posedge clk) disable iff (rst)
    analog_level < refs.reference_bottom_level |-> quant_code == CODE_ZERO)
    else $error("level below bottom did not give all zeros");

  a_above_top: assert property (
    @(posedge clk) disable iff (rst)
    (analog_level > refs.reference_top_level &&
     refs.reference_top_level > refs.reference_bottom_level)
    |-> quant_code == CODE_FULL)
    else $error("level above top did not give all ones");

  a_free_running: assert property (
    @(posedge clk) disable iff (rst)
    run |=> stage1_q == $past(hold_q))
    else $error("pipeline did not advance while running");

  a_word_per_cycle: assert property (
    @(posedge clk) disable iff (rst)
    run |=> data_word_q == $past(stage2_q))
    else $error("no new output word this cycle");

  a_rise_change: assert property (
    @(posedge clk) disable iff (rst)
    data_word_q != $past(data_word_q) |-> $past(run))
    else $error("output changed without an advancing edge");

  a_sleep_hold: assert property (
    @(posedge clk) disable iff (rst)
    sleep_request_pin ##1 sleep_request_pin |-> $stable(data_word_q))
    else $error("output changed during sleep");

  a_stop_hold: assert property (
    @(posedge clk) disable iff (rst)
    !clk_en |=> $stable(data_word_q) && $stable(stage2_q))
    else $error("state changed with the clock stopped");

  c_full_scale: cover property (
    @(posedge clk) disable iff (rst) run && data_word_q == CODE_FULL);

  c_sleep_exit: cover property (
    @(posedge clk) disable iff (rst)
    sleep_request_pin ##1 !sleep_request_pin ##1 run[*3]);

  c_clock_stop: cover property (
    @(posedge clk) disable iff (rst) run ##1 !clk_en[*2] ##1 run);

endmodule : adc_output_port
`default_nettype wire

// ### adc_port_pkg.sv
package adc_port_pkg;

  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W  = 8;
  localparam int unsigned LEVEL_W = 16;
  localparam logic [WORD_W-1:0] CODE_ZERO  = 8'h00;
  localparam logic [WORD_W-1:0] CODE_FULL  = 8'hFF;
  localparam logic [WORD_W-1:0] RESET_CODE = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned LATENCY_HALF_CYCLES = 5;
  localparam int unsigned RISE_STAGES         = 3;

  typedef struct packed {
    logic [LEVEL_W-1:0] reference_top_level;
    logic [LEVEL_W-1:0] reference_bottom_level;
  } ref_levels_t;

endpackage : adc_port_pkg

// ### level_quantizer.sv
`timescale 1ns/1ps
`default_nettype none
module level_quantizer
(
  input  wire logic [15:0]               level,
  input  wire adc_port_pkg::ref_levels_t refs,
  output logic [7:0]                     code
);
  import adc_port_pkg::*;

  logic [LEVEL_W+WORD_W-1:0] num;
  logic [LEVEL_W+WORD_W-1:0] den;
  logic [LEVEL_W+WORD_W-1:0] quo;

  always_comb
  begin
    num = {level - refs.reference_bottom_level, CODE_ZERO};
    den = {CODE_ZERO, refs.reference_top_level - refs.reference_bottom_level};
    quo = '0;
    if (level <= refs.reference_bottom_level)
    begin
      code = CODE_ZERO;
    end
    else if (level >= refs.reference_top_level)
    begin
      code = CODE_FULL;
    end
    else
    begin
      quo  = num / den;
      code = quo[WORD_W-1:0];
    end
  end

endmodule : level_quantizer
`default_nettype wire

// ### pipe_stage.sv
`timescale 1ns/1ps
`default_nettype none
module pipe_stage #(
  parameter int unsigned W = 8
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         adv,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else if (adv)
      q <= d;
  end

endmodule : pipe_stage
`default_nettype wire

// ### word_capture.sv
`timescale 1ns/1ps
`default_nettype none
module word_capture
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic sleep,
  output logic      valid
);
  logic [1:0] seen_q;
  // Words are taken at the falling edge and counted after wake-up.
  // A stopped clock or a sleep both restart the settling count.
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      seen_q <= 2'h0;
    else if (sleep)
      seen_q <= 2'h0;
    else if (!clk_en)
      seen_q <= 2'h0;
    else if (seen_q != 2'h3)
      seen_q <= seen_q + 2'h1;
  end
  assign valid = (seen_q == 2'h3);
endmodule : word_capture
`default_nettype wire

// ### pipelined_adc_output_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pipelined_adc_output_port_bench;
  import adc_port_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        sleep = 1'b0;
  logic [15:0] level = 16'h1000;
  ref_levels_t refs = '{16'h2000, 16'h1000};
  logic [7:0]  word;
  logic        valid;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  adc_output_port dut_u (.clk(clk), .rst(rst), .clk_en(clk_en),
    .sleep_request_pin(sleep), .analog_level(level), .refs(refs),
    .data_word_q(word));
  word_capture cap_u (.clk(clk), .rst(rst), .clk_en(clk_en), .sleep(sleep),
    .valid(valid));
  initial forever #5 clk = ~clk;
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic drive(logic [15:0] l);
    @(posedge clk);
    level <= l;
  endtask : drive
  task automatic conv(logic [15:0] l, logic [7:0] old, logic [7:0] e);
    drive(l);
    repeat (3) @(negedge clk);
    check("word early", word, old);
    @(negedge clk);
    check("word", word, e);
    $display("test conv %h done", l);
  endtask : conv
  task automatic pair();
    drive(16'h1400);
    drive(16'h1C00);
    repeat (3) @(negedge clk);
    check("first word", word, 8'h40);
    @(negedge clk);
    check("second word", word, 8'hC0);
    $display("test pair done");
  endtask : pair
  task automatic freeze(logic use_sleep, logic [15:0] l, logic [7:0] e);
    logic [7:0] held;
    held = word;
    @(posedge clk);
    if (use_sleep)
      sleep <= 1'b1;
    else
      clk_en <= 1'b0;
    level <= l;
    repeat (6)
    begin
      @(negedge clk);
      check("held word", word, held);
    end
    @(posedge clk);
    sleep <= 1'b0;
    clk_en <= 1'b1;
    @(negedge clk);
    check("valid early", {7'h00, valid}, 8'h00);
    repeat (3) @(negedge clk);
    check("word after wake", word, e);
    check("valid late", {7'h00, valid}, 8'h01);
    $display("test freeze %b done", use_sleep);
  endtask : freeze
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    conv(16'h1800, 8'h00, 8'h80);
    conv(16'h0800, 8'h80, 8'h00);
    conv(16'h3000, 8'h00, 8'hFF);
    pair();
    freeze(1'b1, 16'h1800, 8'h80);
    freeze(1'b0, 16'h3000, 8'hFF);
    print_verdict();
  end
endmodule : pipelined_adc_output_port_bench
`default_nettype wire
